// ---- pkg/paor_pkg.sv ----
package paor_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_P1_HIGH_CTRL = 8'ha3;
  localparam logic [7:0] IDX_P3_LOW_CTRL = 8'ha4;
  localparam logic [7:0] IDX_P3_HIGH_CTRL = 8'ha5;
  localparam logic [7:0] IDX_ALT_OUT_EN = 8'ha6;
  localparam logic [7:0] IDX_ROUTE_STATUS = 8'ha7;

  localparam logic [7:0] RST_P1_HIGH_CTRL = 8'h00;
  localparam logic [7:0] RST_P3_LOW_CTRL = 8'h55;
  localparam logic [7:0] RST_P3_HIGH_CTRL = 8'h00;
  localparam logic [7:0] RST_ALT_OUT_EN = 8'h00;
  // Bit 6 of the port3 high register is reserved and reads zero
  localparam logic [7:0] P3H_WMASK = 8'hbf;

  // Bit positions inside the enable registers
  localparam int BIT_T0_OUT_EN = 7;
  localparam int BIT_PWM_B_PRI = 7;
  localparam int BIT_PWM_B_SEC = 6;
  localparam int BIT_PWM_A_PRI = 5;
  localparam int BIT_PWM_A_SEC = 4;
  localparam int BIT_CLK_OUT = 3;
  localparam int BIT_T2_OUT = 2;
  localparam int BIT_SEG19 = 1;
  localparam int BIT_SEG18 = 0;

  // Pin positions inside each port
  localparam int PIN_T0 = 4;
  localparam int PIN_PWM_B_PRI = 3;
  localparam int PIN_PWM_B_SEC = 3;
  localparam int PIN_PWM_A_PRI = 2;
  localparam int PIN_PWM_A_SEC = 2;
  localparam int PIN_CLK = 4;
  localparam int PIN_T2 = 0;

  localparam logic [7:0] PIN_RST = 8'hff;
  localparam int T0_DIV = 64;
  localparam int T2_DIV = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    PAOR_BUS_IDLE = 1'b0,
    PAOR_BUS_ACK = 1'b1
  } paor_bus_state_e;
endpackage : paor_pkg

// ---- pkg/paor_route_if.sv ----
`timescale 1ns/1ps
interface paor_route_if;
  logic [7:0] alt_en;
  logic t0_out_en;
  logic timer_a_div64_out;
  logic timer_c_div2_out;
  logic sysclk_half_out;

  modport cfg (output alt_en, output t0_out_en,
    input timer_a_div64_out, input timer_c_div2_out, input sysclk_half_out);
  modport div (output timer_a_div64_out, output timer_c_div2_out, output sysclk_half_out);
  modport mux (input alt_en, input t0_out_en,
    input timer_a_div64_out, input timer_c_div2_out, input sysclk_half_out);
endinterface : paor_route_if

// ---- logic/paor_dividers.sv ----
`timescale 1ns/1ps
module paor_dividers #(
  parameter int T0_RATIO = paor_pkg::T0_DIV,
  parameter int T2_RATIO = paor_pkg::T2_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic t0_ovf_i,
  input wire logic t2_ovf_i,
  paor_route_if.div rt
);
  import paor_pkg::*;
  localparam int T0_HALF = T0_RATIO / 2;
  localparam int T2_HALF = T2_RATIO / 2;
  localparam int T0_CW = (T0_HALF > 1) ? $clog2(T0_HALF) : 1;
  localparam int T2_CW = (T2_HALF > 1) ? $clog2(T2_HALF) : 1;

  logic [T0_CW-1:0] t0_cnt_ff, nxt_t0_cnt;
  logic [T2_CW-1:0] t2_cnt_ff, nxt_t2_cnt;
  logic t0_out_ff, nxt_t0_out;
  logic t2_out_ff, nxt_t2_out;
  logic ck_half_ff, nxt_ck_half;

  // Output toggles every half ratio of overflows, giving one period per ratio
  always_comb begin
    nxt_t0_cnt = t0_cnt_ff;
    nxt_t0_out = t0_out_ff;
    nxt_t2_cnt = t2_cnt_ff;
    nxt_t2_out = t2_out_ff;
    nxt_ck_half = ~ck_half_ff;
    if (t0_ovf_i) begin
      if (t0_cnt_ff == T0_CW'(T0_HALF - 1)) begin
        nxt_t0_cnt = '0;
        nxt_t0_out = ~t0_out_ff;
      end else begin
        nxt_t0_cnt = t0_cnt_ff + T0_CW'(1);
      end
    end
    if (t2_ovf_i) begin
      if (t2_cnt_ff == T2_CW'(T2_HALF - 1)) begin
        nxt_t2_cnt = '0;
        nxt_t2_out = ~t2_out_ff;
      end else begin
        nxt_t2_cnt = t2_cnt_ff + T2_CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t0_cnt_ff <= '0;
      t0_out_ff <= 1'b0;
      t2_cnt_ff <= '0;
      t2_out_ff <= 1'b0;
      ck_half_ff <= 1'b0;
    end else begin
      t0_cnt_ff <= nxt_t0_cnt;
      t0_out_ff <= nxt_t0_out;
      t2_cnt_ff <= nxt_t2_cnt;
      t2_out_ff <= nxt_t2_out;
      ck_half_ff <= nxt_ck_half;
    end
  end

  assign rt.timer_a_div64_out = t0_out_ff;
  assign rt.timer_c_div2_out = t2_out_ff;
  assign rt.sysclk_half_out = ck_half_ff;
endmodule : paor_dividers

// ---- logic/paor_pin_mux.sv ----
`timescale 1ns/1ps
module paor_pin_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] p1_data_i,
  input wire logic [7:0] p2_data_i,
  input wire logic [7:0] p3_data_i,
  input wire logic pwm_a_i,
  input wire logic pwm_b_i,
  input wire logic seg18_i,
  input wire logic seg19_i,
  paor_route_if.mux rt,
  output logic [7:0] p1_pin_o,
  output logic [7:0] p2_pin_o,
  output logic [7:0] p3_pin_o
);
  import paor_pkg::*;
  logic [7:0] p1_ff, nxt_p1;
  logic [7:0] p2_ff, nxt_p2;
  logic [7:0] p3_ff, nxt_p3;

  // Latch data is the default; each enabled alternate overrides its pin
  always_comb begin
    nxt_p1 = p1_data_i;
    nxt_p2 = p2_data_i;
    nxt_p3 = p3_data_i;
    if (rt.t0_out_en) nxt_p3[PIN_T0] = rt.timer_a_div64_out;
    if (rt.alt_en[BIT_PWM_A_PRI]) nxt_p1[PIN_PWM_A_PRI] = pwm_b_i;
    if (rt.alt_en[BIT_PWM_B_PRI]) nxt_p1[PIN_PWM_B_PRI] = pwm_a_i;
    if (rt.alt_en[BIT_CLK_OUT]) nxt_p1[PIN_CLK] = rt.sysclk_half_out;
    if (rt.alt_en[BIT_T2_OUT]) nxt_p1[PIN_T2] = rt.timer_c_div2_out;
    // Segment drive wins over the PWM copy when both claim the pin
    if (rt.alt_en[BIT_SEG19]) begin
      nxt_p2[PIN_PWM_B_SEC] = seg19_i;
    end else if (rt.alt_en[BIT_PWM_B_SEC]) begin
      nxt_p2[PIN_PWM_B_SEC] = pwm_a_i;
    end
    if (rt.alt_en[BIT_SEG18]) begin
      nxt_p2[PIN_PWM_A_SEC] = seg18_i;
    end else if (rt.alt_en[BIT_PWM_A_SEC]) begin
      nxt_p2[PIN_PWM_A_SEC] = pwm_b_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_ff <= PIN_RST;
      p2_ff <= PIN_RST;
      p3_ff <= PIN_RST;
    end else begin
      p1_ff <= nxt_p1;
      p2_ff <= nxt_p2;
      p3_ff <= nxt_p3;
    end
  end

  assign p1_pin_o = p1_ff;
  assign p2_pin_o = p2_ff;
  assign p3_pin_o = p3_ff;
endmodule : paor_pin_mux

// ---- logic/paor_top.sv ----
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module paor_top #(
  parameter int T0_RATIO = paor_pkg::T0_DIV,
  parameter int T2_RATIO = paor_pkg::T2_DIV
) (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic [paor_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [paor_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [paor_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic [1:0] AVS_RESPONSE_O,
  input wire logic T0_OVF_I,
  input wire logic T2_OVF_I,
  input wire logic PWM_A_I,
  input wire logic PWM_B_I,
  input wire logic SEG18_I,
  input wire logic SEG19_I,
  input wire logic [7:0] P1_DATA_I,
  input wire logic [7:0] P2_DATA_I,
  input wire logic [7:0] P3_DATA_I,
  output logic [7:0] P1_PIN_O,
  output logic [7:0] P2_PIN_O,
  output logic [7:0] P3_PIN_O,
  output logic [7:0] P1_HIGH_CTRL_O,
  output logic [7:0] P3_LOW_CTRL_O,
  output logic [5:0] P3_HIGH_CTRL_O
);
  import paor_pkg::*;

  paor_bus_state_e state_ff, nxt_state;
  logic wait_ff, nxt_wait;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0] resp_ff, nxt_resp;
  logic [7:0] p1h_ff, nxt_p1h;
  logic [7:0] p3l_ff, nxt_p3l;
  logic [7:0] p3h_ff, nxt_p3h;
  logic [7:0] alt_ff, nxt_alt;
  logic [7:0] idx;
  logic req;
  logic wr_commit;

  paor_route_if rt ();

  function automatic logic idx_mapped(input logic [7:0] i);
    return (i == IDX_P1_HIGH_CTRL) || (i == IDX_P3_LOW_CTRL) ||
      (i == IDX_P3_HIGH_CTRL) || (i == IDX_ALT_OUT_EN) || (i == IDX_ROUTE_STATUS);
  endfunction : idx_mapped

  assign idx = AVS_ADDRESS_I[ADDR_W-1:2];
  assign req = AVS_READ_I | AVS_WRITE_I;
  // A write lands only at the edge where the master sees waitrequest low
  assign wr_commit = AVS_WRITE_I && (state_ff == PAOR_BUS_ACK) && AVS_BYTEENABLE_I[0];

  // Bus handshake: one wait cycle, then a single ready cycle per request
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    nxt_resp = resp_ff;
    case (state_ff)
      PAOR_BUS_IDLE: begin
        if (req) begin
          nxt_state = PAOR_BUS_ACK;
          nxt_wait = 1'b0;
          nxt_resp = idx_mapped(idx) ? RESP_OKAY : RESP_SLVERR;
          nxt_rdata = '0;
          if (AVS_READ_I) begin
            case (idx)
              IDX_P1_HIGH_CTRL: nxt_rdata[7:0] = p1h_ff;
              IDX_P3_LOW_CTRL: nxt_rdata[7:0] = p3l_ff;
              IDX_P3_HIGH_CTRL: nxt_rdata[7:0] = p3h_ff;
              IDX_ALT_OUT_EN: nxt_rdata[7:0] = alt_ff;
              IDX_ROUTE_STATUS: nxt_rdata[2:0] = {rt.sysclk_half_out,
                rt.timer_c_div2_out, rt.timer_a_div64_out};
              default: nxt_rdata = '0;
            endcase
          end
        end
      end
      PAOR_BUS_ACK: begin
        nxt_state = PAOR_BUS_IDLE;
        nxt_wait = 1'b1;
        nxt_resp = RESP_OKAY;
      end
      default: begin
        nxt_state = PAOR_BUS_IDLE;
        nxt_wait = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state_ff <= PAOR_BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= '0;
      resp_ff <= RESP_OKAY;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
    end
  end

  // Register file; status index is read-only and writes to it are dropped
  always_comb begin
    nxt_p1h = p1h_ff;
    nxt_p3l = p3l_ff;
    nxt_p3h = p3h_ff;
    nxt_alt = alt_ff;
    if (wr_commit) begin
      case (idx)
        IDX_P1_HIGH_CTRL: nxt_p1h = AVS_WRITEDATA_I[7:0];
        IDX_P3_LOW_CTRL: nxt_p3l = AVS_WRITEDATA_I[7:0];
        IDX_P3_HIGH_CTRL: nxt_p3h = AVS_WRITEDATA_I[7:0] & P3H_WMASK;
        IDX_ALT_OUT_EN: nxt_alt = AVS_WRITEDATA_I[7:0];
        default: nxt_alt = alt_ff;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      p1h_ff <= RST_P1_HIGH_CTRL;
      p3l_ff <= RST_P3_LOW_CTRL;
      p3h_ff <= RST_P3_HIGH_CTRL;
      alt_ff <= RST_ALT_OUT_EN;
    end else begin
      p1h_ff <= nxt_p1h;
      p3l_ff <= nxt_p3l;
      p3h_ff <= nxt_p3h;
      alt_ff <= nxt_alt;
    end
  end

  assign rt.alt_en = alt_ff;
  assign rt.t0_out_en = p3h_ff[BIT_T0_OUT_EN];

  paor_dividers #(
    .T0_RATIO(T0_RATIO),
    .T2_RATIO(T2_RATIO)
  ) u_div (
    .clk_i(CLK_SYS_I),
    .rst_i(SRST_I),
    .t0_ovf_i(T0_OVF_I),
    .t2_ovf_i(T2_OVF_I),
    .rt(rt.div)
  );

  paor_pin_mux u_mux (
    .clk_i(CLK_SYS_I),
    .rst_i(SRST_I),
    .p1_data_i(P1_DATA_I),
    .p2_data_i(P2_DATA_I),
    .p3_data_i(P3_DATA_I),
    .pwm_a_i(PWM_A_I),
    .pwm_b_i(PWM_B_I),
    .seg18_i(SEG18_I),
    .seg19_i(SEG19_I),
    .rt(rt.mux),
    .p1_pin_o(P1_PIN_O),
    .p2_pin_o(P2_PIN_O),
    .p3_pin_o(P3_PIN_O)
  );

  assign AVS_READDATA_O = rdata_ff;
  assign AVS_WAITREQUEST_O = wait_ff;
  assign AVS_RESPONSE_O = resp_ff;
  assign P1_HIGH_CTRL_O = p1h_ff;
  assign P3_LOW_CTRL_O = p3l_ff;
  assign P3_HIGH_CTRL_O = p3h_ff[5:0];
endmodule : paor_top

// ---- verif/paor_checker.sv ----
`timescale 1ns/1ps
module paor_checker (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic [paor_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [paor_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [1:0] AVS_RESPONSE_O,
  input wire logic T2_OVF_I,
  input wire logic PWM_A_I,
  input wire logic PWM_B_I,
  input wire logic SEG18_I,
  input wire logic SEG19_I,
  input wire logic [7:0] P1_DATA_I,
  input wire logic [7:0] P1_PIN_O,
  input wire logic [7:0] P2_PIN_O
);
  import paor_pkg::*;
  logic [7:0] en_ff;
  logic [7:0] nxt_en;
  logic [2:0] warm_ff, nxt_warm;
  logic warm;
  logic [7:0] idx;
  assign idx = AVS_ADDRESS_I[9:2];
  // Shadow of the enables, so pin checks know what software asked for
  // Pin checks look up to three cycles back, so they wait until that history is post-reset
  assign warm = (warm_ff == 3'h4);
  always_comb begin
    nxt_warm = warm ? warm_ff : warm_ff + 3'h1;
    nxt_en = en_ff;
    if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] && idx == IDX_ALT_OUT_EN) begin
      nxt_en = AVS_WRITEDATA_I[7:0];
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    en_ff <= SRST_I ? 8'h00 : nxt_en;
    warm_ff <= SRST_I ? 3'h0 : nxt_warm;
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  sequence bus_take;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence bus_done;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  wait_ack_a: assert property (bus_take |=> bus_done)
    else $error("waitrequest answer wrong");
  wait_cause_a: assert property (!AVS_WAITREQUEST_O |-> $past(AVS_READ_I || AVS_WRITE_I))
    else $error("answer without request");
  resp_code_a: assert property (!AVS_WAITREQUEST_O |-> AVS_RESPONSE_O ==
    ((idx inside {[8'ha3:8'ha7]}) ? RESP_OKAY : RESP_SLVERR)) else $error("bad response");
  pwm_a_pri_a: assert property (warm && $past(en_ff[7]) |->
    P1_PIN_O[3] == $past(PWM_A_I)) else $error("P1.3 not first pwm");
  pwm_a_copy_a: assert property (warm && $past(en_ff[6] && !en_ff[1]) |->
    P2_PIN_O[3] == $past(PWM_A_I)) else $error("P2.3 not first pwm copy");
  pwm_b_pri_a: assert property (warm && $past(en_ff[5]) |->
    P1_PIN_O[2] == $past(PWM_B_I)) else $error("P1.2 not second pwm");
  pwm_b_copy_a: assert property (warm && $past(en_ff[4] && !en_ff[0]) |->
    P2_PIN_O[2] == $past(PWM_B_I)) else $error("P2.2 not second pwm copy");
  seg19_route_a: assert property (warm && $past(en_ff[1]) |->
    P2_PIN_O[3] == $past(SEG19_I)) else $error("P2.3 not segment");
  seg18_route_a: assert property (warm && $past(en_ff[0]) |->
    P2_PIN_O[2] == $past(SEG18_I)) else $error("P2.2 not segment");
  clk_half_a: assert property (warm && $past(en_ff[3]) && $past(en_ff[3], 2) &&
    $past(en_ff[3], 3) |-> P1_PIN_O[4] != $past(P1_PIN_O[4])) else $error("P1.4 not toggling");
  t2_toggle_a: assert property (warm && $past(en_ff[2]) && $past(en_ff[2], 2) &&
    $past(en_ff[2], 3) |-> (P1_PIN_O[0] != $past(P1_PIN_O[0])) == $past(T2_OVF_I, 2))
    else $error("P1.0 toggle wrong");
  latch_pass_a: assert property (!$past(SRST_I) && $past(en_ff) == 8'h00 |->
    P1_PIN_O == $past(P1_DATA_I)) else $error("P1 not latch");
endmodule : paor_checker
bind paor_top paor_checker i_paor_checker (.CLK_SYS_I, .SRST_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_WAITREQUEST_O, .AVS_RESPONSE_O,
  .T2_OVF_I, .PWM_A_I, .PWM_B_I, .SEG18_I, .SEG19_I, .P1_DATA_I, .P1_PIN_O, .P2_PIN_O);

// ---- verif/paor_pin_load.sv ----
`timescale 1ns/1ps
module paor_pin_load (
  input wire logic clk_i,
  input wire logic arm_i,
  input wire logic [7:0] p1_i,
  input wire logic [7:0] p3_i,
  output int clk_cnt_o,
  output int t2_cnt_o,
  output int t0_cnt_o
);
  logic [7:0] p1_ff;
  logic [7:0] p3_ff;
  // The far side only sees levels, so it counts edges while armed
  always @(posedge clk_i) begin
    if (arm_i) begin
      clk_cnt_o <= clk_cnt_o + int'(p1_i[4] != p1_ff[4]);
      t2_cnt_o <= t2_cnt_o + int'(p1_i[0] != p1_ff[0]);
      t0_cnt_o <= t0_cnt_o + int'(p3_i[4] != p3_ff[4]);
    end else begin
      clk_cnt_o <= 0;
      t2_cnt_o <= 0;
      t0_cnt_o <= 0;
    end
    p1_ff <= p1_i;
    p3_ff <= p3_i;
  end
endmodule : paor_pin_load

// ---- verif/port_alternate_output_routing_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, g); miscompares++; end end
module port_alternate_output_routing_tb;
  import paor_pkg::*;
  logic clk = 0, srst = 1, rd = 0, wr = 0, t0_ovf = 0, t2_ovf = 0, arm = 0;
  logic pwm_a = 0, pwm_b = 0, seg18 = 0, seg19 = 0, wreq;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat, rdv;
  logic [3:0] be = 4'h1;
  logic [1:0] resp, rsv;
  logic [7:0] p1d = 0, p2d = 0, p3d = 0, p1o, p2o, p3o, c1, c3l, v, en;
  logic [5:0] c3h;
  logic [7:0] rst_v [4] = '{8'h00, 8'h55, 8'h00, 8'h00};
  int miscompares = 0, tests_run = 0, clk_cnt, t2_cnt, t0_cnt;
  paor_top i_paor_top (.CLK_SYS_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .AVS_RESPONSE_O(resp), .T0_OVF_I(t0_ovf), .T2_OVF_I(t2_ovf),
    .PWM_A_I(pwm_a), .PWM_B_I(pwm_b), .SEG18_I(seg18), .SEG19_I(seg19), .P1_DATA_I(p1d),
    .P2_DATA_I(p2d), .P3_DATA_I(p3d), .P1_PIN_O(p1o), .P2_PIN_O(p2o), .P3_PIN_O(p3o),
    .P1_HIGH_CTRL_O(c1), .P3_LOW_CTRL_O(c3l), .P3_HIGH_CTRL_O(c3h));
  paor_pin_load i_paor_pin_load (.clk_i(clk), .arm_i(arm), .p1_i(p1o), .p3_i(p3o),
    .clk_cnt_o(clk_cnt), .t2_cnt_o(t2_cnt), .t0_cnt_o(t0_cnt));
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [15:0] exp_pins(logic [7:0] e, logic [7:0] a, logic [7:0] b,
    logic pa, logic pb, logic s18, logic s19);
    if (e[7]) a[3] = pa;
    if (e[5]) a[2] = pb;
    if (e[6]) b[3] = pa;
    if (e[4]) b[2] = pb;
    // Segment routing wins over the pwm copy on a shared pin
    if (e[1]) b[3] = s19;
    if (e[0]) b[2] = s18;
    return {a, b};
  endfunction : exp_pins
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
    @(posedge clk);
    adr <= {ix, 2'b00};
    wr <= w;
    rd <= !w;
    wdat <= {24'h0, d};
    // No latency is assumed here; only the watchdog ends a wait that never finishes
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rdv = rdat;
    rsv = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic drive_rand();
    p1d <= 8'($urandom);
    p2d <= 8'($urandom);
    p3d <= 8'($urandom);
    {pwm_a, pwm_b, seg18, seg19} <= 4'($urandom);
    repeat (2) @(posedge clk);
  endtask : drive_rand
  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    void'($urandom(24));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(8'ha3 + i), 8'h00);
      `CHK("reset value", rst_v[i], rdv[7:0])
    end
    repeat (4) begin
      v = 8'($urandom);
      bus(1'b1, IDX_P1_HIGH_CTRL, v);
      bus(1'b1, IDX_P3_LOW_CTRL, v);
      bus(1'b1, IDX_P3_HIGH_CTRL, v);
      bus(1'b0, IDX_P3_HIGH_CTRL, 8'h00);
      `CHK("p3 high field", v & P3H_WMASK, rdv[7:0])
      `CHK("field ports", {v, v, v[5:0]}, {c1, c3l, c3h})
    end
    be <= 4'h0;
    bus(1'b1, IDX_P1_HIGH_CTRL, ~v);
    be <= 4'h1;
    bus(1'b0, IDX_P1_HIGH_CTRL, 8'h00);
    `CHK("masked write", v, rdv[7:0])
    bus(1'b0, 8'h10, 8'h00);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {rsv, rdv})
    bus(1'b1, IDX_P3_HIGH_CTRL, 8'h00);
    for (int k = 0; k < 24; k++) begin
      en = (k == 0) ? 8'hf3 : 8'($urandom) & 8'hf3;
      bus(1'b1, IDX_ALT_OUT_EN, en);
      drive_rand();
      `CHK("p1 p2 pins", exp_pins(en, p1d, p2d, pwm_a, pwm_b, seg18, seg19), {p1o, p2o})
      `CHK("p3 pins", p3d, p3o)
    end
    bus(1'b1, IDX_P3_HIGH_CTRL, 8'h80);
    bus(1'b1, IDX_ALT_OUT_EN, 8'h0c);
    repeat (3) @(posedge clk);
    arm <= 1'b1;
    for (int j = 0; j < 64; j++) begin
      t0_ovf <= 1'b1;
      t2_ovf <= (j < 5);
      @(posedge clk);
      t0_ovf <= 1'b0;
      t2_ovf <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    arm <= 1'b0;
    @(posedge clk);
    `CHK("sysclk half edges", 132, clk_cnt)
    `CHK("timer2 edges", 5, t2_cnt)
    `CHK("timer0 edges", 64 / (T0_DIV / 2), t0_cnt)
    // Status holds divider levels: five timer2 toggles leave it high
    bus(1'b0, IDX_ROUTE_STATUS, 8'h00);
    `CHK("route status", {29'h0, 1'b1, 1'((64 / (T0_DIV / 2)) % 2)}, {rdv[31:3], rdv[1:0]})
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, IDX_ALT_OUT_EN, 8'h00);
    `CHK("enables after reset", 8'h00, rdv[7:0])
    drive_rand();
    `CHK("pins after reset", {p1d, p2d, p3d}, {p1o, p2o, p3o})
    give_verdict();
  end
endmodule : port_alternate_output_routing_tb
